// >>> phy_cfg_regs.svh
// constant macros for the transceiver power, test and configuration registers
// How it works
// [R1] power-down select bits 15..9 read zero and ignore writes
// [R2] each set select bit makes that sub-block follow the common level
// [R3] common power-down level: 1 powers down, 0 runs normally
// [R4] force signal detect 1 makes 100M signal detect always good
// [R5] preamble shortened only when preamble-normal is 0 and 10M saving set
// [R6] length select 1 removes 12 preamble bits, 0 removes 22
// [R7] 10M transmit power-save bit enables or disables the saving
// [R8] negotiation power-save bit inverted: 1 disables, 0 enables saving
// [R9] read-only status bit shows crossover state, 1 crossed, 0 straight
// [R10] crossover override 1 disables automatic crossover, 0 enables it
// [R11] under override the crossover state takes the force-value bit
// [R12] negotiation loopback bit routes negotiation logic into loopback
// [R13] amplitude reduction applies only when set and no link partner
// [R14] drive current saving applies only when set and no link partner
// [R15] software writes zero to reserved config bit 1
// [R16] 16-bit test control register holds writes, resets to zero
// [R17] vendor test and monitor selects are plain read-write, reset zero
// [R18] all registers 16 bits, whole-word access, reserved bits read zero except config bit 1, which is stored
`ifndef PHY_CFG_REGS_SVH
`define PHY_CFG_REGS_SVH

// ==========================================
// register indices, byte address is index times four
`define IDX_POWER_DOWN_SELECT 6'h13
`define IDX_SPECIFIED_CONFIG 6'h14
`define IDX_INTERNAL_TEST_CONTROL 6'h1b
`define IDX_POWER_SAVING_CONTROL 6'h1d

// ==========================================
// writable masks and reset values
`define MASK_POWER_DOWN_SELECT 16'h01ff
`define MASK_SPECIFIED_CONFIG 16'hfe7f
`define MASK_INTERNAL_TEST_CONTROL 16'hffff
`define MASK_POWER_SAVING_CONTROL 16'h0e00
`define RST_REG16 16'h0000

// ==========================================
// config register fields
`define CFG_VENDOR_SEL_A 15
`define CFG_VENDOR_SEL_B 14
`define CFG_FORCE_SD 13
`define CFG_VENDOR_SEL_C 12
`define CFG_PREAMBLE_NORMAL 11
`define CFG_TEN_TX_SAVE 10
`define CFG_NEG_SAVE_OFF 9
`define CFG_XOVER_STATE 7
`define CFG_NEG_LOOPBACK 6
`define CFG_XOVER_FORCE_VAL 5
`define CFG_XOVER_OVERRIDE 4
`define CFG_MON_SEL_HI 3
`define CFG_MON_SEL_LO 2
`define CFG_RESERVED_1 1
`define CFG_COMMON_PD 0

// ==========================================
// power saving register fields
`define PSV_PREAMBLE_LEN_SEL 11
`define PSV_AMPLITUDE_SAVE 10
`define PSV_DRIVE_SAVE 9

// ==========================================
// preamble reduction amounts in bits
`define PREAMBLE_CUT_SHORT 5'h0c
`define PREAMBLE_CUT_LONG 5'h16

`define PD_SEL_COUNT 9
`endif

// >>> phy_cfg_pkg.sv
// types shared by the transceiver configuration register bank
`default_nettype none
package phy_cfg_pkg;
  // controls handed to the analog and negotiation logic
  typedef struct packed {
    logic [8:0] pd_state;
    logic force_signal_detect;
    logic preamble_shorten_ctl;
    logic [4:0] preamble_cut_bits;
    logic ten_meg_tx_power_save;
    logic negotiation_power_save;
    logic auto_crossover_en;
    logic crossover_state;
    logic negotiation_loopback;
    logic amplitude_reduce;
    logic drive_current_save;
  } phy_ctl_t;

  // wishbone slave answer
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_resp_t;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_t;
endpackage
`default_nettype wire

// >>> phy_power_test_config_regs.sv
// register bank for transceiver power-down, test, config and power saving
`include "phy_cfg_regs.svh"
`default_nettype none
module phy_power_test_config_regs
  import phy_cfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [8:0] pd_normal,
  input wire logic auto_crossover_detect,
  input wire logic link_partner_present,
  output var phy_ctl_t phy_ctl,
  output logic [15:0] test_ctl_out
);

  // ==========================================
  // storage
  logic [15:0] pd_select_ff;
  logic [15:0] config_ff;
  logic [15:0] test_ctl_ff;
  logic [15:0] power_save_ff;
  logic xover_state_ff;
  bus_state_t bus_ff;
  wb_resp_t resp_ff;
  phy_ctl_t ctl_ff;
  phy_ctl_t nxt_ctl;
  logic [8:0] nxt_pd_state;
  logic [31:0] nxt_rdata;
  logic [15:0] cfg_view;
  logic [5:0] reg_idx;
  logic req;
  logic wr_en;
  logic wr_full;

  // word addressed: low two byte-address bits ignored
  assign reg_idx = wb_adr_i[7:2];
  assign req = wb_cyc_i && wb_stb_i && (bus_ff == BUS_IDLE);
  // only whole 16-bit writes take effect, partial lanes are dropped
  assign wr_full = (wb_sel_i[1:0] == 2'b11);
  assign wr_en = req && wb_we_i && wr_full && clk_en; // R18

  // ==========================================
  // bus handshake: ack one cycle after request, dropped next cycle
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      bus_ff <= BUS_IDLE;
    else if (clk_en)
    begin
      case (bus_ff)
        BUS_IDLE:
        begin
          if (wb_cyc_i && wb_stb_i)
            bus_ff <= BUS_ACK;
        end
        BUS_ACK: bus_ff <= BUS_IDLE;
        default: bus_ff <= BUS_IDLE;
      endcase
    end
  end

  // ==========================================
  // power-down select: upper bits never stored
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      pd_select_ff <= `RST_REG16;
    else if (wr_en && reg_idx == `IDX_POWER_DOWN_SELECT)
      pd_select_ff <= wb_dat_i[15:0] & `MASK_POWER_DOWN_SELECT; // R1
  end

  // config register; status bit 7 and reserved 8 not stored
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      config_ff <= `RST_REG16;
    else if (wr_en && reg_idx == `IDX_SPECIFIED_CONFIG)
      config_ff <= wb_dat_i[15:0] & `MASK_SPECIFIED_CONFIG; // R17
  end

  // test register is opaque storage for internal testing
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      test_ctl_ff <= `RST_REG16;
    else if (wr_en && reg_idx == `IDX_INTERNAL_TEST_CONTROL)
      test_ctl_ff <= wb_dat_i[15:0]; // R16
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      power_save_ff <= `RST_REG16;
    else if (wr_en && reg_idx == `IDX_POWER_SAVING_CONTROL)
      power_save_ff <= wb_dat_i[15:0] & `MASK_POWER_SAVING_CONTROL;
  end

  // ==========================================
  // crossover state: override wins, else follow the detector
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      xover_state_ff <= 1'b0;
    else if (clk_en)
    begin
      if (config_ff[`CFG_XOVER_OVERRIDE])
        xover_state_ff <= config_ff[`CFG_XOVER_FORCE_VAL]; // R11
      else
        xover_state_ff <= auto_crossover_detect; // R10
    end
  end

  // ==========================================
  // per sub-block power-down steering
  genvar gi;
  generate
    for (gi = 0; gi < `PD_SEL_COUNT; gi++)
    begin : g_pd
      // selected block follows the common level, 1 means powered down
      assign nxt_pd_state[gi] = pd_select_ff[gi] ?
        config_ff[`CFG_COMMON_PD] : pd_normal[gi]; // R2 R3
    end
  endgenerate

  // remaining control outputs decoded from the stored bits
  always_comb
  begin
    nxt_ctl.pd_state = nxt_pd_state; // R2
    nxt_ctl.force_signal_detect = config_ff[`CFG_FORCE_SD]; // R4
    nxt_ctl.ten_meg_tx_power_save = config_ff[`CFG_TEN_TX_SAVE]; // R7
    // shorten only with normal-preamble bit clear and 10M saving on
    nxt_ctl.preamble_shorten_ctl = !config_ff[`CFG_PREAMBLE_NORMAL]
      && config_ff[`CFG_TEN_TX_SAVE]; // R5
    if (!nxt_ctl.preamble_shorten_ctl)
      nxt_ctl.preamble_cut_bits = 5'h00;
    else if (power_save_ff[`PSV_PREAMBLE_LEN_SEL])
      nxt_ctl.preamble_cut_bits = `PREAMBLE_CUT_SHORT; // R6
    else
      nxt_ctl.preamble_cut_bits = `PREAMBLE_CUT_LONG; // R6
    nxt_ctl.negotiation_power_save = !config_ff[`CFG_NEG_SAVE_OFF]; // R8
    nxt_ctl.auto_crossover_en = !config_ff[`CFG_XOVER_OVERRIDE]; // R10
    nxt_ctl.crossover_state = xover_state_ff; // R11
    nxt_ctl.negotiation_loopback = config_ff[`CFG_NEG_LOOPBACK]; // R12
    // savings only while the cable has no partner
    nxt_ctl.amplitude_reduce = power_save_ff[`PSV_AMPLITUDE_SAVE]
      && !link_partner_present; // R13
    nxt_ctl.drive_current_save = power_save_ff[`PSV_DRIVE_SAVE]
      && !link_partner_present; // R14
  end

  // ==========================================
  // registered control outputs
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      ctl_ff <= '0;
    else if (clk_en)
      ctl_ff <= nxt_ctl;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      test_ctl_out <= `RST_REG16;
    else if (clk_en)
      test_ctl_out <= test_ctl_ff;
  end

  // ==========================================
  // read mux; status bit overlays config, unmapped reads zero
  always_comb
  begin
    cfg_view = config_ff;
    cfg_view[`CFG_XOVER_STATE] = xover_state_ff; // R9
    nxt_rdata = 32'h0000_0000;
    case (reg_idx)
      `IDX_POWER_DOWN_SELECT: nxt_rdata = {16'h0000, pd_select_ff}; // R1
      `IDX_SPECIFIED_CONFIG: nxt_rdata = {16'h0000, cfg_view};
      `IDX_INTERNAL_TEST_CONTROL: nxt_rdata = {16'h0000, test_ctl_ff};
      `IDX_POWER_SAVING_CONTROL: nxt_rdata = {16'h0000, power_save_ff}; // R18
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  // answer every request, mapped or not, after one cycle
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      resp_ff <= '0;
    else if (clk_en)
    begin
      resp_ff.ack <= req;
      if (req && !wb_we_i)
        resp_ff.dat <= nxt_rdata;
    end
  end

  assign wb_ack_o = resp_ff.ack;
  assign wb_dat_o = resp_ff.dat;
  assign phy_ctl = ctl_ff;

  // ==========================================
  // checks
  property p_pd_upper_zero;
    @(posedge ref_clk) disable iff (rst)
      pd_select_ff[15:9] == 7'h00;
  endproperty
  a_pd_upper_zero: assert property (p_pd_upper_zero) // R1
    else $error("power-down select upper bits not zero");

  property p_pd_follow;
    @(posedge ref_clk) disable iff (rst)
      clk_en && pd_select_ff[0] |=> ctl_ff.pd_state[0] == $past(config_ff[0]);
  endproperty
  a_pd_follow: assert property (p_pd_follow) // R2
    else $error("selected sub-block ignores common level");

  property p_shorten;
    @(posedge ref_clk) disable iff (rst)
      clk_en && config_ff[11] |=> !ctl_ff.preamble_shorten_ctl;
  endproperty
  a_shorten: assert property (p_shorten) // R5
    else $error("preamble shortened with normal bit set");

  property p_cut_len;
    @(posedge ref_clk) disable iff (rst)
      ctl_ff.preamble_shorten_ctl |->
        ctl_ff.preamble_cut_bits == 5'h0c || ctl_ff.preamble_cut_bits == 5'h16;
  endproperty
  a_cut_len: assert property (p_cut_len) // R6
    else $error("preamble cut amount wrong");

  property p_neg_save;
    @(posedge ref_clk) disable iff (rst)
      clk_en |=> ctl_ff.negotiation_power_save == !$past(config_ff[9]);
  endproperty
  a_neg_save: assert property (p_neg_save) // R8
    else $error("negotiation power save sense wrong");

  property p_xover_force;
    @(posedge ref_clk) disable iff (rst)
      clk_en && config_ff[4] |=> xover_state_ff == $past(config_ff[5]);
  endproperty
  a_xover_force: assert property (p_xover_force) // R11
    else $error("crossover state not forced");

  property p_amp;
    @(posedge ref_clk) disable iff (rst)
      clk_en && link_partner_present |=> !ctl_ff.amplitude_reduce && !ctl_ff.drive_current_save;
  endproperty
  a_amp: assert property (p_amp) // R13
    else $error("saving active with link partner present");

  property p_ack_pulse;
    @(posedge ref_clk) disable iff (rst)
      wb_ack_o && clk_en |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) // R18
    else $error("ack held more than one cycle");

  // unselected sub-blocks keep their normal level
  property p_pd_normal;
    @(posedge ref_clk) disable iff (rst)
      clk_en && !pd_select_ff[0] |=> ctl_ff.pd_state[0] == $past(pd_normal[0]);
  endproperty
  a_pd_normal: assert property (p_pd_normal) // R2
    else $error("unselected sub-block left normal control");

  property p_force_sd;
    @(posedge ref_clk) disable iff (rst)
      clk_en |=> ctl_ff.force_signal_detect == $past(config_ff[13]);
  endproperty
  a_force_sd: assert property (p_force_sd) // R4
    else $error("forced signal detect wrong");

  // both conditions met means the preamble must be cut
  property p_shorten_on;
    @(posedge ref_clk) disable iff (rst)
      clk_en && !config_ff[11] && config_ff[10] |=> ctl_ff.preamble_shorten_ctl;
  endproperty
  a_shorten_on: assert property (p_shorten_on) // R5
    else $error("preamble not shortened");

  property p_cut_sel;
    @(posedge ref_clk) disable iff (rst)
      clk_en && !config_ff[11] && config_ff[10] |=>
        ctl_ff.preamble_cut_bits == ($past(power_save_ff[11]) ? 5'h0c : 5'h16);
  endproperty
  a_cut_sel: assert property (p_cut_sel) // R6
    else $error("preamble cut amount ignores length select");

  property p_ten_save;
    @(posedge ref_clk) disable iff (rst)
      clk_en |=> ctl_ff.ten_meg_tx_power_save == $past(config_ff[10]);
  endproperty
  a_ten_save: assert property (p_ten_save) // R7
    else $error("10M transmit saving wrong");

  property p_auto_xover;
    @(posedge ref_clk) disable iff (rst)
      clk_en |=> ctl_ff.auto_crossover_en == !$past(config_ff[4]);
  endproperty
  a_auto_xover: assert property (p_auto_xover) // R10
    else $error("automatic crossover enable wrong");

  // without override the detector result is taken one edge later
  property p_xover_follow;
    @(posedge ref_clk) disable iff (rst)
      clk_en && !config_ff[4] |=> xover_state_ff == $past(auto_crossover_detect);
  endproperty
  a_xover_follow: assert property (p_xover_follow) // R10
    else $error("crossover state ignores detector");

  property p_loopback;
    @(posedge ref_clk) disable iff (rst)
      clk_en |=> ctl_ff.negotiation_loopback == $past(config_ff[6]);
  endproperty
  a_loopback: assert property (p_loopback) // R12
    else $error("negotiation loopback wrong");

  property p_amp_on;
    @(posedge ref_clk) disable iff (rst)
      clk_en && !link_partner_present |=> ctl_ff.amplitude_reduce == $past(power_save_ff[10]);
  endproperty
  a_amp_on: assert property (p_amp_on) // R13
    else $error("amplitude reduction wrong without partner");

  property p_drive;
    @(posedge ref_clk) disable iff (rst)
      clk_en && !link_partner_present |=> ctl_ff.drive_current_save == $past(power_save_ff[9]);
  endproperty
  a_drive: assert property (p_drive) // R14
    else $error("drive current saving wrong without partner");

  property p_test_out;
    @(posedge ref_clk) disable iff (rst)
      clk_en |=> test_ctl_out == $past(test_ctl_ff);
  endproperty
  a_test_out: assert property (p_test_out) // R16
    else $error("test control copy wrong");

  // reserved storage other than config bit 1 must never hold ones
  property p_rsvd;
    @(posedge ref_clk) disable iff (rst)
      config_ff[8:7] == 2'b00 && power_save_ff[15:12] == 4'h0
        && power_save_ff[8:0] == 9'h000;
  endproperty
  a_rsvd: assert property (p_rsvd) // R18
    else $error("reserved register bits not zero");

  c_write_cfg: cover property (@(posedge ref_clk) disable iff (rst) wr_en && reg_idx == 6'h14);
  c_shorten: cover property (@(posedge ref_clk) disable iff (rst) ctl_ff.preamble_shorten_ctl);
  c_xover: cover property (@(posedge ref_clk) disable iff (rst) config_ff[4] && xover_state_ff);
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench for the transceiver power, test and config register bank
`default_nettype none
module tb
  import phy_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // clock, reset and design hookup
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r;
  logic ack;
  logic [8:0] pd_normal = 9'h0a3;
  logic xdet = 1'b0;
  logic lp = 1'b0;
  logic ce = 1'b1;
  phy_ctl_t ctl;
  logic [15:0] test_ctl_out;
  logic [31:0] q;
  int n_fail = 0;
  int n_checks = 0;
  always #20 ref_clk = ~ref_clk;
  phy_power_test_config_regs phy_power_test_config_regs_inst (.ref_clk(ref_clk), .rst(rst),
    .clk_en(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .pd_normal(pd_normal), .auto_crossover_detect(xdet), .link_partner_present(lp),
    .phy_ctl(ctl), .test_ctl_out(test_ctl_out));
  // ==========================================
  // bus, compare and closing tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  // one classic cycle; held until ack is sampled, then a cycle idle
  task automatic xfer(input logic [7:0] a, input logic w, input logic [15:0] d,
    input logic [3:0] s);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat_w <= {16'h0000, d};
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = dat_r;
    if (n >= 20) chk("ack", 32'h1, 32'h0);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    xfer(a, 1'b1, d, 4'hf);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [15:0] e);
    xfer(a, 1'b0, 16'h0000, 4'hf);
    chk(nm, {16'h0000, e}, q);
  endtask
  // registered controls need two edges after a write or input change
  task automatic settle();
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================
  // watchdog, far above the few hundred cycles the tests take
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    stop_test();
  end
  // ==========================================
  // test sequence
  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    settle();
    rd("pd_sel_rst", 8'h4c, 16'h0000);
    rd("cfg_rst", 8'h50, 16'h0000);
    rd("test_rst", 8'h6c, 16'h0000);
    rd("psv_rst", 8'h74, 16'h0000);
    chk("neg_save_rst", 32'h1, ctl.negotiation_power_save);
    chk("pd_rst", pd_normal, ctl.pd_state);
    // reserved upper select bits stay zero
    wr(8'h4c, 16'hffff);
    rd("pd_sel_mask", 8'h4c, 16'h01ff);
    wr(8'h4c, 16'h0155);
    wr(8'h50, 16'h0001);
    settle();
    chk("pd_on", 9'h155 | (~9'h155 & pd_normal), ctl.pd_state);
    wr(8'h50, 16'h0000);
    settle();
    chk("pd_off", ~9'h155 & pd_normal, ctl.pd_state);
    // all writable config bits except reserved bit 1, with override forcing crossed mode
    wr(8'h50, 16'hfe7d);
    settle();
    rd("cfg_all", 8'h50, 16'hfefd);
    chk("fsd", 32'h1, ctl.force_signal_detect);
    chk("neg_save_off", 32'h0, ctl.negotiation_power_save);
    chk("xover_en_off", 32'h0, ctl.auto_crossover_en);
    chk("xover_forced", 32'h1, ctl.crossover_state);
    chk("loopback_on", 32'h1, ctl.negotiation_loopback);
    // automatic crossover follows the detector
    xdet <= 1'b1;
    wr(8'h50, 16'h0000);
    settle();
    rd("cfg_auto", 8'h50, 16'h0080);
    chk("xover_auto", 32'h1, ctl.crossover_state);
    chk("xover_en_on", 32'h1, ctl.auto_crossover_en);
    chk("fsd_off", 32'h0, ctl.force_signal_detect);
    chk("loopback_off", 32'h0, ctl.negotiation_loopback);
    // override to straight even though detector says crossed
    wr(8'h50, 16'h0010);
    settle();
    rd("cfg_force0", 8'h50, 16'h0010);
    chk("xover_force0", 32'h0, ctl.crossover_state);
    // every preamble combination: normal bit, 10M saving, length select
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h50, {4'h0, i[0], i[1], 10'h000});
      wr(8'h74, {4'h0, i[2], 11'h000});
      settle();
      chk("shorten", !i[0] && i[1], ctl.preamble_shorten_ctl);
      chk("cut", (!i[0] && i[1]) ? (i[2] ? 5'h0c : 5'h16) : 5'h00,
        ctl.preamble_cut_bits);
      chk("tx10_save", i[1], ctl.ten_meg_tx_power_save);
    end
    // amplitude and drive saving gated by link partner presence
    for (int i = 0; i < 8; i++)
    begin
      lp <= i[2];
      wr(8'h74, {4'hf, 1'b0, i[1], i[0], 9'h1ff});
      settle();
      rd("psv_mask", 8'h74, {5'h00, i[1], i[0], 9'h000});
      chk("amp", i[1] && !i[2], ctl.amplitude_reduce);
      chk("drive", i[0] && !i[2], ctl.drive_current_save);
    end
    // frozen enable holds the crossover state while the detector moves
    ce <= 1'b0;
    xdet <= 1'b0;
    settle();
    chk("xover_frozen", 32'h1, ctl.crossover_state);
    ce <= 1'b1;
    settle();
    settle();
    chk("xover_thawed", 32'h0, ctl.crossover_state);
    // test register, partial select write, unmapped place
    wr(8'h6c, 16'ha5c3);
    xfer(8'h6c, 1'b1, 16'h1234, 4'h1);
    rd("test_hold", 8'h6c, 16'ha5c3);
    chk("test_out", 32'ha5c3, test_ctl_out);
    wr(8'h78, 16'hffff);
    rd("unmapped", 8'h78, 16'h0000);
    stop_test();
  end
endmodule
`default_nettype wire
